// [inc/rlt_pkg.sv]
// Constants, types and register decode for the 8-bit reload timer.
// Assumes a 32-bit APB slave with byte addresses on paddr[7:0].
package rlt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PRIO = 8'h00;
    localparam logic [7:0] OFF_STBY = 8'h04;
    localparam logic [7:0] OFF_RUN = 8'h08;
    localparam logic [7:0] OFF_IRQC = 8'h0c;
    localparam logic [7:0] OFF_PRE = 8'h10;
    localparam logic [7:0] OFF_PRI = 8'h14;
    localparam logic [7:0] OFF_EVST = 8'h18;
    localparam logic [7:0] OFF_EVMSK = 8'h1c;
    localparam logic [7:0] OFF_CNT = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PRIO_LSB = 0;
    localparam int STBY_BIT = 1;
    localparam int RUN_BIT = 0;
    localparam int STAT_BIT = 1;
    localparam int FSTOP_BIT = 2;
    localparam int IR_BIT = 6;
    localparam int IE_BIT = 7;
    localparam int NEV = 3;
    localparam int EV_UNDER = 0;
    localparam int EV_START = 1;
    localparam int EV_STOP = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_PRIO = 2'h0;
    localparam logic RST_STBY = 1'b1;
    localparam logic [7:0] RST_RELOAD = 8'hff;
    localparam logic [NEV-1:0] RST_MSK = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        REG_PRIO, REG_STBY, REG_RUN, REG_IRQC, REG_PRE,
        REG_PRI, REG_EVST, REG_EVMSK, REG_CNT, REG_NONE
    } rlt_reg_e;

    typedef enum logic [1:0] {RUN_IDLE, RUN_ARM, RUN_CNT, RUN_HALT} rlt_run_e;

    typedef struct packed {
        logic stb;
        rlt_reg_e id;
        logic [7:0] data;
    } rlt_wr_s;

    function automatic rlt_reg_e rlt_decode(input logic [7:0] addr);
        case (addr)
            OFF_PRIO: rlt_decode = REG_PRIO;
            OFF_STBY: rlt_decode = REG_STBY;
            OFF_RUN: rlt_decode = REG_RUN;
            OFF_IRQC: rlt_decode = REG_IRQC;
            OFF_PRE: rlt_decode = REG_PRE;
            OFF_PRI: rlt_decode = REG_PRI;
            OFF_EVST: rlt_decode = REG_EVST;
            OFF_EVMSK: rlt_decode = REG_EVMSK;
            OFF_CNT: rlt_decode = REG_CNT;
            default: rlt_decode = REG_NONE;
        endcase
    endfunction

endpackage

// [rtl/rlt_apb_slave.sv]
// APB slave front end: decodes, strobes writes, registers read data.
// Assumes the owner returns read data combinationally for rd_id.
`timescale 1ns/1ps
`default_nettype none

module rlt_apb_slave (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output rlt_pkg::rlt_wr_s wr,
    output rlt_pkg::rlt_reg_e rd_id,
    input wire logic [31:0] rd_data
);

    typedef struct packed {
        logic [31:0] rdata;
    } rlt_apb_s;

    rlt_apb_s st_reg;
    rlt_apb_s st_next;
    logic access;

    assign rd_id = rlt_pkg::rlt_decode(paddr);
    assign access = psel && penable;
    // Zero wait states; data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access && (rd_id == rlt_pkg::REG_NONE);
    // One driver for the whole strobe bundle
    assign wr = '{stb: access && pwrite && (rd_id != rlt_pkg::REG_NONE),
                  id: rd_id,
                  data: pwdata[7:0]};
    assign prdata = st_reg.rdata;

    always_comb begin
        st_next = st_reg;
        if (psel && !penable && !pwrite) begin
            st_next.rdata = rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// [rtl/rlt_down8.sv]
// 8-bit down counter that reloads itself when it passes zero.
// Assumes load and dec are synchronous single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module rlt_down8 (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [7:0] reload,
    input wire logic dec,
    output logic [7:0] count,
    output logic underflow
);

    typedef struct packed {
        logic [7:0] cnt;
    } rlt_cnt_s;

    rlt_cnt_s st_reg;
    rlt_cnt_s st_next;

    assign count = st_reg.cnt;
    assign underflow = dec && !load && (st_reg.cnt == 8'h00);

    always_comb begin
        st_next = st_reg;
        if (load || underflow) begin
            st_next.cnt = reload;
        end else if (dec) begin
            st_next.cnt = st_reg.cnt - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{cnt: rlt_pkg::RST_RELOAD};
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// [rtl/rlt_timer.sv]
// Reload timer top: APB registers, run control, counters, irq gating.
// Assumes count_tick is a one-cycle pulse of the prescaled count source,
// synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module rlt_timer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick,
    output logic irq,
    output logic [1:0] irq_level,
    output logic count_active,
    output logic underflow
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] prio;
        logic stby;
        logic run;
        logic ie;
        logic ir;
        logic [7:0] pre_rl;
        logic [7:0] pri_rl;
        logic [rlt_pkg::NEV-1:0] ev;
        logic [rlt_pkg::NEV-1:0] msk;
        rlt_pkg::rlt_run_e fsm;
        logic irq;
        logic uf;
    } rlt_state_s;

    localparam rlt_state_s ST_RESET = '{
        prio: rlt_pkg::RST_PRIO,
        stby: rlt_pkg::RST_STBY,
        run: 1'b0,
        ie: 1'b0,
        ir: 1'b0,
        pre_rl: rlt_pkg::RST_RELOAD,
        pri_rl: rlt_pkg::RST_RELOAD,
        ev: '0,
        msk: rlt_pkg::RST_MSK,
        fsm: rlt_pkg::RUN_IDLE,
        irq: 1'b0,
        uf: 1'b0
    };

    rlt_state_s st_reg;
    rlt_state_s st_next;

    rlt_pkg::rlt_wr_s wr;
    rlt_pkg::rlt_reg_e rd_id;
    logic [31:0] rd_data;

    logic active;
    logic tick;
    logic fstop;
    logic [7:0] pre_rl_new;
    logic [7:0] pri_rl_new;
    logic pre_load;
    logic pri_load;
    logic pre_dec;
    logic [7:0] pre_cnt;
    logic [7:0] pri_cnt;
    logic pre_uf;
    logic pri_uf;

    function automatic logic wr_to(input rlt_pkg::rlt_wr_s w,
                                   input rlt_pkg::rlt_reg_e id);
        wr_to = w.stb && (w.id == id);
    endfunction

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    rlt_apb_slave u_apb (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wr(wr),
        .rd_id(rd_id),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------
    // Counting path
    // ------------------------------------------------------------
    // Standby gates the count source, so every sync step freezes too
    assign tick = count_tick && !st_reg.stby;

    // Running flag covers the wait for the stopping source edge
    assign active = (st_reg.fsm == rlt_pkg::RUN_CNT)
                 || (st_reg.fsm == rlt_pkg::RUN_HALT);

    assign fstop = wr_to(wr, rlt_pkg::REG_RUN) && wr.data[rlt_pkg::FSTOP_BIT];

    // Reload writes land in both reload register and counter
    always_comb begin
        pre_rl_new = st_reg.pre_rl;
        pri_rl_new = st_reg.pri_rl;
        if (fstop) begin
            pre_rl_new = rlt_pkg::RST_RELOAD;
            pri_rl_new = rlt_pkg::RST_RELOAD;
        end else begin
            if (wr_to(wr, rlt_pkg::REG_PRE)) begin
                pre_rl_new = wr.data;
            end
            if (wr_to(wr, rlt_pkg::REG_PRI)) begin
                pri_rl_new = wr.data;
            end
        end
    end

    assign pre_load = fstop || wr_to(wr, rlt_pkg::REG_PRE);
    assign pri_load = fstop || wr_to(wr, rlt_pkg::REG_PRI);

    // Only the running state consumes source edges
    assign pre_dec = (st_reg.fsm == rlt_pkg::RUN_CNT) && tick;

    rlt_down8 u_pre (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .load(pre_load),
        .reload(pre_rl_new),
        .dec(pre_dec),
        .count(pre_cnt),
        .underflow(pre_uf)
    );

    // Primary steps on prescaler underflow; both reload on their own
    rlt_down8 u_pri (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .load(pri_load),
        .reload(pri_rl_new),
        .dec(pre_uf),
        .count(pri_cnt),
        .underflow(pri_uf)
    );

    // ------------------------------------------------------------
    // Control and interrupt state
    // ------------------------------------------------------------
    always_comb begin
        logic [rlt_pkg::NEV-1:0] ev_set;
        logic [rlt_pkg::NEV-1:0] ev_clr;
        ev_set = '0;
        ev_clr = '0;
        st_next = st_reg;

        if (wr_to(wr, rlt_pkg::REG_PRIO)) begin
            st_next.prio = wr.data[rlt_pkg::PRIO_LSB +: 2];
        end
        if (wr_to(wr, rlt_pkg::REG_STBY)) begin
            st_next.stby = wr.data[rlt_pkg::STBY_BIT];
        end
        if (wr_to(wr, rlt_pkg::REG_RUN)) begin
            st_next.run = wr.data[rlt_pkg::RUN_BIT];
        end
        if (wr_to(wr, rlt_pkg::REG_IRQC)) begin
            st_next.ie = wr.data[rlt_pkg::IE_BIT];
        end
        if (wr_to(wr, rlt_pkg::REG_EVMSK)) begin
            st_next.msk = wr.data[rlt_pkg::NEV-1:0];
        end
        if (wr_to(wr, rlt_pkg::REG_EVST)) begin
            ev_clr = wr.data[rlt_pkg::NEV-1:0];
        end
        st_next.pre_rl = pre_rl_new;
        st_next.pri_rl = pri_rl_new;

        // Start and stop resynchronise to the count source edge
        case (st_reg.fsm)
            rlt_pkg::RUN_IDLE: begin
                if (st_reg.run) begin
                    st_next.fsm = rlt_pkg::RUN_ARM;
                end
            end
            rlt_pkg::RUN_ARM: begin
                if (!st_reg.run) begin
                    st_next.fsm = rlt_pkg::RUN_IDLE;
                end else if (tick) begin
                    st_next.fsm = rlt_pkg::RUN_CNT;
                    ev_set[rlt_pkg::EV_START] = 1'b1;
                end
            end
            rlt_pkg::RUN_CNT: begin
                if (!st_reg.run) begin
                    st_next.fsm = rlt_pkg::RUN_HALT;
                end
            end
            rlt_pkg::RUN_HALT: begin
                if (st_reg.run) begin
                    st_next.fsm = rlt_pkg::RUN_CNT;
                end else if (tick) begin
                    st_next.fsm = rlt_pkg::RUN_IDLE;
                    ev_set[rlt_pkg::EV_STOP] = 1'b1;
                end
            end
            default: begin
                st_next.fsm = rlt_pkg::RUN_IDLE;
            end
        endcase

        // Forced stop overrides any pending start or stop
        if (fstop) begin
            st_next.run = 1'b0;
            st_next.fsm = rlt_pkg::RUN_IDLE;
            ev_set[rlt_pkg::EV_START] = 1'b0;
            ev_set[rlt_pkg::EV_STOP] = active;
        end

        ev_set[rlt_pkg::EV_UNDER] = pri_uf;

        // Writing one leaves the request alone; an underflow wins a clear
        if (wr_to(wr, rlt_pkg::REG_IRQC) && !wr.data[rlt_pkg::IR_BIT]) begin
            st_next.ir = 1'b0;
        end
        if (pri_uf) begin
            st_next.ir = 1'b1;
        end
        st_next.ev = (st_reg.ev & ~ev_clr) | ev_set;

        st_next.irq = (st_next.prio != 2'h0)
                   && ((st_next.ie && st_next.ir)
                   || ((st_next.ev & st_next.msk) != '0));
        st_next.uf = pri_uf;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Forced-stop bit has no storage, so it always reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_id)
            rlt_pkg::REG_PRIO: begin
                rd_data[rlt_pkg::PRIO_LSB +: 2] = st_reg.prio;
            end
            rlt_pkg::REG_STBY: begin
                rd_data[rlt_pkg::STBY_BIT] = st_reg.stby;
            end
            rlt_pkg::REG_RUN: begin
                rd_data[rlt_pkg::RUN_BIT] = st_reg.run;
                rd_data[rlt_pkg::STAT_BIT] = active;
            end
            rlt_pkg::REG_IRQC: begin
                rd_data[rlt_pkg::IE_BIT] = st_reg.ie;
                rd_data[rlt_pkg::IR_BIT] = st_reg.ir;
            end
            rlt_pkg::REG_PRE: begin
                rd_data[7:0] = st_reg.pre_rl;
            end
            rlt_pkg::REG_PRI: begin
                rd_data[7:0] = st_reg.pri_rl;
            end
            rlt_pkg::REG_EVST: begin
                rd_data[rlt_pkg::NEV-1:0] = st_reg.ev;
            end
            rlt_pkg::REG_EVMSK: begin
                rd_data[rlt_pkg::NEV-1:0] = st_reg.msk;
            end
            rlt_pkg::REG_CNT: begin
                rd_data[15:0] = {pri_cnt, pre_cnt};
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign irq = st_reg.irq;
    assign irq_level = st_reg.prio;
    assign underflow = st_reg.uf;

    // Decoded straight from the state register, in step with the flag read
    always_comb begin
        count_active = (st_reg.fsm == rlt_pkg::RUN_CNT)
                    || (st_reg.fsm == rlt_pkg::RUN_HALT);
    end

endmodule

`default_nettype wire

// [testbench/rlt_timer_sva.sv]
// Checker for the reload timer top: bus answer, stop control, irq gating.
// Assumes it is bound to rlt_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module rlt_timer_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_tick,
    input wire logic irq,
    input wire logic [1:0] irq_level,
    input wire logic count_active,
    input wire logic underflow
);
    logic acc;
    logic mapped;

    assign acc = psel && penable;
    // Map is every aligned word from 00 up to 20
    assign mapped = (paddr <= 8'h20) && (paddr[1:0] == 2'h0);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_fstop_wr;
        acc && pwrite && paddr == rlt_pkg::OFF_RUN && pwdata[2];
    endsequence

    sequence s_run_rd;
        acc && !pwrite && paddr == rlt_pkg::OFF_RUN;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_access_ready: assert property (acc |-> pready)
        else $error("access phase without ready");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_fstop_halts: assert property (s_fstop_wr |=> !count_active [*2])
        else $error("forced stop left counting on");
    chk_fstop_reads0: assert property (s_run_rd |-> prdata[31:2] == 30'h0)
        else $error("forced stop bit read as one");
    chk_level_blocks: assert property (irq_level == 2'h0 && $past(irq_level) == 2'h0 |-> !irq)
        else $error("irq raised at level zero");
    chk_start_tick: assert property ($rose(count_active) |-> $past(count_tick) || $past(count_tick, 2))
        else $error("running flag rose without a tick");
    chk_under_tick: assert property (underflow |-> $past(count_tick) || $past(count_tick, 2))
        else $error("underflow without a tick");
endmodule

bind rlt_timer rlt_timer_sva rlt_timer_sva_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick(count_tick), .irq(irq),
    .irq_level(irq_level), .count_active(count_active), .underflow(underflow)
);

`default_nettype wire

// [testbench/rlt_timer_tb_top.sv]
// Self-checking bench for the reload timer top, driven over APB.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none

module rlt_timer_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic count_tick = 1'b0;
    logic tick_en = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, count_active, underflow;
    logic [1:0] irq_level;
    logic [31:0] rd;
    logic err;
    logic [7:0] pre_v [2] = '{8'h01, 8'hff};
    logic [7:0] pri_v [2] = '{8'h02, 8'h00};
    int n_mismatch = 0;
    int n_checks = 0;
    int ticks;

    always #10 ref_clk = ~ref_clk;
    // Count source at half the bus clock, one-cycle pulses
    always @(posedge ref_clk) count_tick <= tick_en && !count_tick;

    rlt_timer rlt_timer_inst (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_tick(count_tick), .irq(irq),
        .irq_level(irq_level), .count_active(count_active), .underflow(underflow)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic fail(input string name);
        n_mismatch++;
        $display("wrong value %s expected event seen timeout", name);
        close_out();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask

    task automatic wait_run(input logic want);
        int n;
        n = 0;
        do begin
            apb(1'b0, rlt_pkg::OFF_RUN, 32'h0);
            n++;
        end while (rd[1] !== want && n < 200);
        if (n >= 200) fail("running status");
    endtask

    // Counts ticks up to the next underflow pulse
    task automatic wait_under();
        int n;
        n = 0;
        ticks = 0;
        do begin
            @(posedge ref_clk);
            ticks += int'(count_tick);
            n++;
        end while (underflow !== 1'b1 && n < 2000);
        if (n >= 2000) fail("underflow");
    endtask

    // Irq is registered one cycle after its cause
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rdchk("priority", rlt_pkg::OFF_PRIO, 32'h0);
        rdchk("standby", rlt_pkg::OFF_STBY, 32'h2);
        rdchk("run control", rlt_pkg::OFF_RUN, 32'h0);
        rdchk("irq control", rlt_pkg::OFF_IRQC, 32'h0);
        rdchk("counters", rlt_pkg::OFF_CNT, 32'hffff);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, rlt_pkg::OFF_PRIO, 32'h0);
        apb(1'b1, rlt_pkg::OFF_STBY, 32'h0);
        apb(1'b1, rlt_pkg::OFF_RUN, 32'h0);
        wait_run(1'b0);
        apb(1'b1, rlt_pkg::OFF_IRQC, 32'h0);
        tick_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, rlt_pkg::OFF_RUN, 32'h4);
            apb(1'b1, rlt_pkg::OFF_PRE, {24'h0, pre_v[i]});
            apb(1'b1, rlt_pkg::OFF_PRI, {24'h0, pri_v[i]});
            apb(1'b1, rlt_pkg::OFF_RUN, 32'h1);
            wait_run(1'b1);
            wait_under();
            wait_under();
            chk("period", 32'(ticks), (32'(pre_v[i]) + 32'h1) * (32'(pri_v[i]) + 32'h1));
        end
        rdchk("request set", rlt_pkg::OFF_IRQC, 32'h40);
        irq_is(1'b0);
        // Stop while running, then check what it reinitialised
        apb(1'b1, rlt_pkg::OFF_RUN, 32'h4);
        rdchk("after forced stop", rlt_pkg::OFF_RUN, 32'h0);
        rdchk("counters reloaded", rlt_pkg::OFF_CNT, 32'hffff);
        rdchk("prescaler reload", rlt_pkg::OFF_PRE, 32'hff);
        rdchk("primary reload", rlt_pkg::OFF_PRI, 32'hff);
        apb(1'b1, rlt_pkg::OFF_RUN, 32'h1);
        wait_run(1'b1);
        apb(1'b1, rlt_pkg::OFF_RUN, 32'h0);
        wait_run(1'b0);
        apb(1'b1, rlt_pkg::OFF_IRQC, 32'hc0);
        irq_is(1'b0);
        apb(1'b1, rlt_pkg::OFF_PRIO, 32'h1);
        irq_is(1'b1);
        chk("irq level", {30'h0, irq_level}, 32'h1);
        apb(1'b1, rlt_pkg::OFF_IRQC, 32'h40);
        irq_is(1'b0);
        apb(1'b1, rlt_pkg::OFF_IRQC, 32'h80);
        rdchk("request cleared", rlt_pkg::OFF_IRQC, 32'h80);
        irq_is(1'b0);
        apb(1'b1, rlt_pkg::OFF_EVMSK, 32'h1);
        irq_is(1'b1);
        apb(1'b1, rlt_pkg::OFF_EVST, 32'h1);
        irq_is(1'b0);
        // Standby freezes the count source even with run set
        apb(1'b1, rlt_pkg::OFF_STBY, 32'h2);
        apb(1'b1, rlt_pkg::OFF_RUN, 32'h1);
        repeat (20) @(posedge ref_clk);
        rdchk("frozen in standby", rlt_pkg::OFF_RUN, 32'h1);
        apb(1'b1, rlt_pkg::OFF_STBY, 32'h0);
        wait_run(1'b1);
        chk("count active", {31'h0, count_active}, 32'h1);
        close_out();
    end
endmodule

`default_nettype wire
